// ===== core/ctp_timer16.sv
`include "ctp_regs.svh"

//////////////////////////////////////////////////////////////////////////////
module ctp_timer16
    import ctp_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_b,
    input  wire logic [7:0]       i_lower_channel_control,
    input  wire logic [7:0]       i_upper_channel_control,
    input  wire logic             i_upper_ctl_we,
    input  wire logic             i_prescale_extra_divide,
    input  wire logic [CNT_W-1:0] i_period_compare,
    input  wire logic             i_period_we,
    input  wire logic [CNT_W-1:0] i_duty_compare,
    input  wire logic             i_duty_we,
    input  wire logic             i_event_input_pin,
    output logic [CNT_W-1:0]      o_duty_readback,
    output logic [CNT_W-1:0]      o_count,
    output logic                  o_upper_channel_irq,
    output logic                  o_output_flip_flop,
    output logic                  o_pwm_output_pin,
    output logic                  o_pulse_gen_output_pin
);
    //////////////////////////////////////////////////////////////////////////
    // control decode
    logic [CNT_W-1:0] period_active;
    logic [CNT_W-1:0] duty_buffer;
    logic [CNT_W-1:0] duty_active;
    logic [7:0]       lower_count;
    logic [7:0]       upper_count;
    logic             event_prev;
    logic             presc_tick;
    logic             count_en;
    logic             running;
    logic             was_running;
    logic             ext_src;
    logic             lower_carry;
    logic             period_hit;
    logic             duty_hit;
    logic             overflow;
    logic             cycle_end;
    logic             duty_load;
    logic [2:0]       mode_bits;
    logic             ctl_tff;
    ctp_mode_e        mode;

    assign mode_bits = i_upper_channel_control[`CTP_UCTL_MODE_MSB:`CTP_UCTL_MODE_LSB];
    assign running   = i_upper_channel_control[`CTP_UCTL_START_BIT];
    assign ctl_tff   = i_upper_channel_control[`CTP_UCTL_TFF_BIT];
    assign ext_src   = (i_lower_channel_control[`CTP_LCTL_SRC_MSB:`CTP_LCTL_SRC_LSB] == `CTP_SRC_EXT);

    always_comb begin
        case (mode_bits)
            `CTP_MODE_TIMER: mode = CTP_TIMER;
            `CTP_MODE_EVENT: mode = CTP_EVENT;
            `CTP_MODE_PWM:   mode = CTP_PWM;
            `CTP_MODE_PPG:   mode = CTP_PPG;
            default:         mode = CTP_TIMER;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // clock source
    ctp_prescaler #(
        .DIV_W(12)
    ) u_prescaler (
        .i_core_clk     (i_core_clk),
        .i_rst_b        (i_rst_b),
        .i_src_sel      (i_lower_channel_control[`CTP_LCTL_SRC_MSB:`CTP_LCTL_SRC_LSB]),
        .i_extra_divide (i_prescale_extra_divide),
        .o_tick         (presc_tick)
    );

    // input is synchronous; external source relies on slow pulses
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            event_prev <= 1'b1;
        end else begin
            event_prev <= i_event_input_pin;
        end
    end

    // event mode always external; pwm/ppg choose; timer internal
    always_comb begin
        case (mode)
            CTP_EVENT: count_en = event_prev & ~i_event_input_pin;
            CTP_PWM,
            CTP_PPG:   count_en = ext_src ? (event_prev & ~i_event_input_pin) : presc_tick;
            default:   count_en = presc_tick;
        endcase
        count_en = count_en & running;
    end

    //////////////////////////////////////////////////////////////////////////
    // chained counter and compares
    assign lower_carry = (lower_count == 8'hFF);
    assign period_hit  = ({upper_count, lower_count} == period_active);
    assign duty_hit    = ({upper_count, lower_count} == duty_active);
    assign overflow    = lower_carry & (upper_count == 8'hFF);
    assign cycle_end   = count_en & ((mode == CTP_PWM) ? overflow : period_hit);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lower_count <= 8'h00;
            upper_count <= 8'h00;
        end else if (!running) begin
            // stopped counter clears so restart begins from zero
            lower_count <= 8'h00;
            upper_count <= 8'h00;
        end else if (cycle_end) begin
            lower_count <= 8'h00;
            upper_count <= 8'h00;
        end else if (count_en) begin
            lower_count <= lower_count + 8'h01;
            if (lower_carry) begin
                upper_count <= upper_count + 8'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_upper_channel_irq <= 1'b0;
        end else begin
            o_upper_channel_irq <= cycle_end;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // compare registers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            period_active <= `CTP_CMP_RST;
        end else if (i_period_we) begin
            period_active <= i_period_compare;
        end
    end

    // load active duty on cycle end or while stopped; outside pwm unbuffered
    assign duty_load = (mode != CTP_PWM) || !running || cycle_end;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            duty_buffer <= `CTP_CMP_RST;
        end else if (i_duty_we) begin
            duty_buffer <= i_duty_compare;
        end
    end

    // a write colliding with cycle end lands next cycle end (buffer
    // is sampled before the write); stopped pwm writes follow one cycle later, non-pwm writes at once
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            duty_active <= `CTP_CMP_RST;
        end else if (duty_load) begin
            duty_active <= (i_duty_we && mode != CTP_PWM) ? i_duty_compare : duty_buffer;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_duty_readback <= `CTP_CMP_RST;
        end else begin
            o_duty_readback <= duty_active;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_count <= '0;
        end else begin
            o_count <= {upper_count, lower_count};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // output flip-flop
    // run state before this edge; tells a stopping write from a later one
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            was_running <= 1'b0;
        end else begin
            was_running <= running;
        end
    end

    // the write that stops the timer leaves the flop alone so the pin holds;
    // only a later write while stopped loads the init bit
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_output_flip_flop <= 1'b0;
        end else if (i_upper_ctl_we && !running && !was_running) begin
            o_output_flip_flop <= ctl_tff;
        end else if (running && (mode == CTP_PWM || mode == CTP_PPG)) begin
            if (cycle_end) begin
                o_output_flip_flop <= ~o_output_flip_flop;
            end else if (count_en && duty_hit) begin
                o_output_flip_flop <= ~o_output_flip_flop;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pwm_output_pin       <= 1'b1;
            o_pulse_gen_output_pin <= 1'b1;
        end else begin
            o_pwm_output_pin       <= ~o_output_flip_flop;
            o_pulse_gen_output_pin <= ~o_output_flip_flop;
        end
    end
endmodule

// ===== core/ctp_regs.svh
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH

// upper channel control bit positions
`define CTP_UCTL_TFF_BIT    7
`define CTP_UCTL_START_BIT  3
`define CTP_UCTL_MODE_MSB   2
`define CTP_UCTL_MODE_LSB   0

// lower channel control bit positions
`define CTP_LCTL_SRC_MSB    6
`define CTP_LCTL_SRC_LSB    4

// upper channel mode field encodings
`define CTP_MODE_TIMER      3'h4
`define CTP_MODE_EVENT      3'h5
`define CTP_MODE_PWM        3'h6
`define CTP_MODE_PPG        3'h7

// lower channel source encodings
`define CTP_SRC_DIV11       3'h0
`define CTP_SRC_DIV7        3'h1
`define CTP_SRC_DIV5        3'h2
`define CTP_SRC_DIV3        3'h3
`define CTP_SRC_EXT         3'h6

// divider tap positions (divide by 2^(n+1) from bit n)
`define CTP_TAP_DIV11       10
`define CTP_TAP_DIV7        6
`define CTP_TAP_DIV5        4
`define CTP_TAP_DIV3        2

// reset values
`define CTP_CTL_RST         8'h00
`define CTP_CMP_RST         16'h0000

`endif

// ===== core/ctp_pkg.sv
package ctp_pkg;
    typedef enum logic [2:0] {
        CTP_TIMER = 3'b100,
        CTP_EVENT = 3'b101,
        CTP_PWM   = 3'b110,
        CTP_PPG   = 3'b111
    } ctp_mode_e;

    typedef logic [15:0] ctp_word_t;
endpackage

// ===== core/ctp_prescaler.sv
`include "ctp_regs.svh"

// free-running divider giving one-cycle ticks at the chosen rate
module ctp_prescaler
    import ctp_pkg::*;
#(
    parameter int DIV_W = 12
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    input  wire logic [2:0] i_src_sel,
    input  wire logic       i_extra_divide,
    output logic            o_tick
);
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] div_prev;
    logic [3:0]       tap;
    logic             fell;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt  <= '0;
            div_prev <= '0;
        end else begin
            div_cnt  <= div_cnt + 1'b1;
            div_prev <= div_cnt;
        end
    end

    // one tap further down when extra divide is set
    always_comb begin
        case (i_src_sel)
            `CTP_SRC_DIV11: tap = 4'(`CTP_TAP_DIV11);
            `CTP_SRC_DIV7:  tap = 4'(`CTP_TAP_DIV7);
            `CTP_SRC_DIV5:  tap = 4'(`CTP_TAP_DIV5);
            default:        tap = 4'(`CTP_TAP_DIV3);
        endcase
        if (i_extra_divide) begin
            tap = tap + 4'h1;
        end
        fell = div_prev[tap] & ~div_cnt[tap];
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= fell;
        end
    end
endmodule

// ===== testbench/ctp_timer16_monitor.sv
module ctp_timer16_monitor
    import ctp_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_b,
    input  wire logic [7:0]       i_upper_channel_control,
    input  wire logic             i_upper_ctl_we,
    input  wire logic [CNT_W-1:0] o_duty_readback,
    input  wire logic [CNT_W-1:0] o_count,
    input  wire logic             o_upper_channel_irq,
    input  wire logic             o_output_flip_flop,
    input  wire logic             o_pwm_output_pin,
    input  wire logic             o_pulse_gen_output_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    wire run = i_upper_channel_control[3];
    wire pwm = i_upper_channel_control[2:0] == CTP_PWM;
    //////////////////////////////////////////////////////////////////////////////
    pwm_pin_inv_a: assert property (o_pwm_output_pin == !$past(o_output_flip_flop))
        else $error("pwm pin not inverse of flop");
    ppg_pin_inv_a: assert property (o_pulse_gen_output_pin == !$past(o_output_flip_flop))
        else $error("ppg pin not inverse of flop");
    irq_pulse_a: assert property (o_upper_channel_irq |=> !o_upper_channel_irq)
        else $error("irq longer than one cycle");
    irq_needs_run_a: assert property (o_upper_channel_irq |-> $past(run) || $past(run, 2))
        else $error("irq while stopped");
    irq_clears_a: assert property (o_upper_channel_irq |-> ##[0:2] o_count == '0)
        else $error("count not cleared at irq");
    count_step_a: assert property ($changed(o_count) |-> o_count == $past(o_count) + 1'b1 || o_count == '0)
        else $error("count jumped");
    stop_clears_a: assert property (!run [*3] |-> o_count == '0)
        else $error("count moves while stopped");
    flop_cause_a: assert property ($changed(o_output_flip_flop) |-> $past(run) || $past(i_upper_ctl_we))
        else $error("flop changed without cause");
    flop_load_a: assert property (i_upper_ctl_we && !run && !$past(run) |=> o_output_flip_flop == $past(i_upper_channel_control[7]))
        else $error("stopped flop write lost");
    stop_hold_a: assert property (i_upper_ctl_we && !run && $past(run) |=> $stable(o_output_flip_flop))
        else $error("stopping write moved the flop");
    // buffered duty only moves around the irq
    duty_hold_a: assert property (run && pwm && $past(run, 3) && $changed(o_duty_readback)
        |-> $past(o_upper_channel_irq) || $past(o_upper_channel_irq, 2) || $past(o_upper_channel_irq, 3))
        else $error("duty moved between irqs");
endmodule

bind ctp_timer16 ctp_timer16_monitor #(.CNT_W(CNT_W)) i_mon (.*);

// ===== testbench/ctp_event_src.sv
module ctp_event_src #(
    parameter int HALF = 8
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_fire,
    input  wire logic [7:0] i_pulses,
    output logic            o_event_input_pin,
    output logic            o_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    // idles high as if pulled up
    initial begin
        o_event_input_pin = 1'b1;
        o_busy = 1'b0;
        forever begin
            @(posedge i_core_clk);
            if (i_fire) begin
                o_busy <= 1'b1;
                repeat (i_pulses) begin
                    o_event_input_pin <= 1'b0;
                    repeat (HALF) @(posedge i_core_clk);
                    o_event_input_pin <= 1'b1;
                    repeat (HALF) @(posedge i_core_clk);
                end
                o_busy <= 1'b0;
            end
        end
    end
endmodule

// ===== testbench/tb_ctp_timer16.sv
module tb_ctp_timer16;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_core_clk, i_rst_b, i_upper_ctl_we, i_prescale_extra_divide;
    logic        i_period_we, i_duty_we, i_event_input_pin, fire, busy;
    logic [7:0]  i_lower_channel_control, i_upper_channel_control, n_pulse;
    logic [15:0] i_period_compare, i_duty_compare, o_duty_readback, o_count;
    logic        o_upper_channel_irq, o_output_flip_flop, o_pwm_output_pin, o_pulse_gen_output_pin;
    int          n_fail, tests_run, n;
    int          tap[4] = '{11, 7, 5, 3};

    ctp_timer16 i_dut (.*);
    ctp_event_src i_src (.i_core_clk(i_core_clk), .i_fire(fire), .i_pulses(n_pulse),
                         .o_event_input_pin(i_event_input_pin), .o_busy(busy));

    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask

    // 0 control, 1 period, 2 duty; words always whole
    task automatic wr(input int k, input logic [15:0] v);
        @(posedge i_core_clk);
        if (k == 0) i_upper_channel_control <= v[7:0];
        if (k == 1) i_period_compare <= v;
        if (k == 2) i_duty_compare <= v;
        i_upper_ctl_we <= (k == 0);
        i_period_we <= (k == 1);
        i_duty_we <= (k == 2);
        @(posedge i_core_clk);
        {i_upper_ctl_we, i_period_we, i_duty_we} <= 3'b000;
    endtask

    task automatic fire_evt(input int k);
        @(posedge i_core_clk);
        n_pulse <= 8'(k);
        fire <= 1'b1;
        @(posedge i_core_clk);
        fire <= 1'b0;
    endtask

    // 0 irq, 1 count equals c, 2 event source idle
    task automatic wait_for(input int sel, input logic [15:0] c, output int t);
        logic hit;
        t = 0;
        do begin
            @(negedge i_core_clk);
            t++;
            hit = sel == 0 ? o_upper_channel_irq === 1'b1 : sel == 1 ? o_count === c : busy !== 1'b1;
        end while (!hit && t < 20000);
        if (!hit) begin
            chk("wait", 16'h0001, 16'h0000);
            report_and_stop();
        end
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        {i_rst_b, i_upper_ctl_we, i_period_we, i_duty_we, i_prescale_extra_divide, fire} = '0;
        {i_period_compare, i_duty_compare, n_pulse} = '0;
        i_lower_channel_control = 8'h30;
        i_upper_channel_control = 8'h04;
        repeat (12) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(negedge i_core_clk);
        chk("reset flop", 16'h0000, o_output_flip_flop);
        chk("reset pin", 16'h0001, o_pwm_output_pin);
        wr(1, 16'h0102);
        wr(0, 16'h000C);
        wait_for(0, 0, n);
        wait_for(0, 0, n);
        chk("carry interval", 16'h0818, n[15:0]);
        for (int x = 0; x < 2; x++) begin
            for (int s = 0; s < 4; s++) begin
                wr(0, 16'h0004);
                i_prescale_extra_divide <= x[0];
                i_lower_channel_control <= {1'b0, s[2:0], 4'h0};
                wr(1, 16'h0001);
                wr(0, 16'h000C);
                wait_for(0, 0, n);
                wait_for(0, 0, n);
                chk("tick interval", 16'(1 << (tap[s] + x + 1)), n[15:0]);
            end
        end
        wr(0, 16'h0005);
        i_prescale_extra_divide <= 1'b0;
        i_lower_channel_control <= 8'h60;
        wr(1, 16'h0004);
        wr(0, 16'h000D);
        fire_evt(4);
        wait_for(2, 0, n);
        chk("event count", 16'h0004, o_count);
        fire_evt(1);
        wait_for(0, 0, n);
        chk("event irq prompt", 16'h0001, 16'(n < 16));
        wait_for(2, 0, n);
        chk("event cleared", 16'h0000, o_count);
        // pwm on the external clock, overflow too far to reach here
        wr(0, 16'h0006);
        wr(2, 16'h0002);
        repeat (3) @(negedge i_core_clk);
        chk("pwm duty stopped", 16'h0002, o_duty_readback);
        wr(0, 16'h000E);
        fire_evt(3);
        wait_for(2, 0, n);
        chk("pwm duty toggle", 16'h0001, o_output_flip_flop);
        wr(2, 16'h0005);
        repeat (3) @(negedge i_core_clk);
        chk("pwm duty buffered", 16'h0002, o_duty_readback);
        wr(0, 16'h0006);
        repeat (3) @(negedge i_core_clk);
        chk("pwm pin held", 16'h0000, o_pwm_output_pin);
        wr(0, 16'h0006);
        repeat (3) @(negedge i_core_clk);
        chk("pwm pin released", 16'h0001, o_pwm_output_pin);
        i_lower_channel_control <= 8'h30;
        wr(1, 16'h0006);
        wr(2, 16'h0002);
        wr(0, 16'h0057);
        repeat (2) @(negedge i_core_clk);
        chk("ppg pin idle", 16'h0001, o_pulse_gen_output_pin);
        wr(0, 16'h005F);
        wait_for(0, 0, n);
        wait_for(0, 0, n);
        chk("ppg period", 16'h0038, n[15:0]);
        chk("ppg flop at period", 16'h0000, o_output_flip_flop);
        wait_for(1, 16'h0003, n);
        chk("ppg pin at duty", 16'h0000, o_pulse_gen_output_pin);
        wr(2, 16'h0004);
        repeat (2) @(negedge i_core_clk);
        chk("ppg duty direct", 16'h0004, o_duty_readback);
        wr(0, 16'h0017);
        repeat (3) @(negedge i_core_clk);
        chk("stopped count", 16'h0000, o_count);
        report_and_stop();
    end
endmodule
